// ---- core/eibc_defs.svh ----
// Register offsets, field positions, reset values for the external request and bank control block.
// Assumes inclusion by the package and the design modules.
`ifndef EIBC_DEFS_SVH
`define EIBC_DEFS_SVH
`define EIBC_OFS_SENSE      8'h00
`define EIBC_OFS_POLARITY   8'h04
`define EIBC_OFS_FLAGS      8'h08
`define EIBC_OFS_LVL_EN     8'h0C
`define EIBC_OFS_LVL_STAT   8'h10
`define EIBC_OFS_BANK_EN    8'h14
`define EIBC_OFS_BANK_NUM   8'h18
`define EIBC_RST_16         16'h0000
`define EIBC_BANK_EN_MASK   16'hFFFE
`define EIBC_BNUM_MASK      16'hE00F
`define EIBC_BANK_OVERFLOW_EXCEPTION_ENABLE_BIT       13
`define EIBC_MODE_HI        15
`define EIBC_MODE_LO        14
`define EIBC_SENSE_LOW      2'h0
`define EIBC_SENSE_FALL     2'h1
`define EIBC_SENSE_RISE     2'h2
`define EIBC_SENSE_BOTH     2'h3
`define EIBC_MODE_OFF       2'h0
`define EIBC_MODE_ALL       2'h1
`define EIBC_MODE_LEVEL     2'h3
`endif

// ---- core/eibc_pkg.sv ----
// Types shared by the external request and bank control block.
// Assumes eibc_defs.svh is on the include path.
`include "eibc_defs.svh"
package eibc_pkg;
    typedef enum logic [1:0] {
        EIBC_BUS_IDLE,
        EIBC_BUS_ACK
    } eibc_bus_type;

    typedef struct packed {
        logic [7:0] pins;
        logic [7:0] prev;
    } eibc_sync_type;

    typedef struct packed {
        logic       accept;
        logic [3:0] level;
        logic       is_nmi;
        logic       is_ubrk;
        logic       restore;
    } eibc_cpu_evt_type;

    typedef struct packed {
        logic [15:0] sense;
        logic [7:0]  polarity;
        logic [7:0]  flags;
        logic [7:0]  armed;
        logic [7:0]  lvl_en;
        logic [15:0] bank_en;
        logic [1:0]  mode;
        logic        bank_overflow_exception_enable;
        logic [3:0]  bank_ptr;
        logic [15:0] dat;
        logic        ack;
        logic        bank_use;
        logic        bank_ovf;
        logic [7:0]  lvl_req;
        eibc_bus_type bus;
    } eibc_state_type;
endpackage

// ---- core/eibc_pin_sync.sv ----
// Two-stage synchroniser plus one previous-sample stage for a group of request pins.
// Assumes pins change slowly against the system clock.
`timescale 1ns/1ps
module eibc_pin_sync import eibc_pkg::*; #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_now,
    output logic      [WIDTH-1:0] pin_prev
);
    logic [WIDTH-1:0] stage1_r;

    initial begin
        if (WIDTH < 1) $error("WIDTH must be at least 1");
    end

    // Reset to all high so idle-high pins show no edge when released
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1_r <= '1;
            pin_now  <= '1;
            pin_prev <= '1;
        end else begin
            stage1_r <= pin_in;
            pin_now  <= stage1_r;
            pin_prev <= pin_now;
        end
    end
endmodule

// ---- core/eibc_edge_detect.sv ----
// Per-pin edge detection selected by a two-bit sense code.
// Assumes synchronised current and previous samples.
`timescale 1ns/1ps
`include "eibc_defs.svh"
module eibc_edge_detect import eibc_pkg::*; #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0]   now_v,
    input  wire logic [WIDTH-1:0]   prev_v,
    input  wire logic [2*WIDTH-1:0] sense,
    output logic      [WIDTH-1:0]   edge_hit,
    output logic      [WIDTH-1:0]   is_level
);
    function automatic logic hit(input logic [1:0] code, input logic n, input logic p);
        logic r;
        r = 1'b0;
        case (code)
            `EIBC_SENSE_FALL: r = p & ~n;
            `EIBC_SENSE_RISE: r = ~p & n;
            `EIBC_SENSE_BOTH: r = p ^ n;
            default:          r = 1'b0;
        endcase
        return r;
    endfunction

    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            edge_hit[i] = hit(sense[2*i+:2], now_v[i], prev_v[i]); // R01 R21
            is_level[i] = (sense[2*i+:2] == `EIBC_SENSE_LOW);      // R01
        end
    end
endmodule

// ---- core/eibc_top.sv ----
// External request detection, request flags and register bank control, Wishbone classic slave.
// Assumes asynchronous pins, synchronised inside, one clock, CPU events as one-cycle pulses.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "eibc_defs.svh"
// How it works
// R01: Two-bit sense per edge pin: 00 low, 01 fall, 10 rise, 11 both.
// R02: Pin n sense code sits in bits 2n+1 and 2n.
// R03: Level-only pin polarity bits 7..0: 0 senses low, 1 senses high.
// R04: Low-level mode flag mirrors an inverted pin, never latched.
// R05: Edge mode flag sets on the selected edge and holds.
// R06: Edge flag clears only by writing 0 after reading it as 1.
// R07: Edge flag also clears when CPU handles that pin's exception.
// R08: Level-only pin enable bits 7..0 block or pass requests.
// R09: Level-only status register is read-only, shows present requests.
// R10: Bank enable bits 15..1 per priority level; bit 0 reads 0.
// R11: User break interrupts never use register banks.
// R12: Bank mode 00 disables banks for all interrupts.
// R13: Bank mode 01 uses banks except NMI and user break.
// R14: Software must not program bank mode 10.
// R15: Bank mode 11 uses per-level enable bit.
// R16: Bank number bit 13 enables the bank overflow exception.
// R17: Read-only pointer names next bank; increments after a bank save.
// R18: Restore decrements the pointer, then restores from that bank.
// R19: Reset clears all registers to zero.
// R20: Reserved bits read 0.
// R21: Pins synchronised; edge sets flag cycle after change is sampled.
module eibc_top import eibc_pkg::*; #(
    parameter int NPINS = 8,
    parameter int NBANK = 15
) (
    input  wire logic               clock,
    input  wire logic               sys_rst,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic [NPINS-1:0]   edge_level_request_pin,
    input  wire logic [NPINS-1:0]   level_only_request_pin,
    input  wire logic               cpu_accept,
    input  wire logic [3:0]         cpu_level,
    input  wire logic               cpu_is_nmi,
    input  wire logic               cpu_is_ubrk,
    input  wire logic [NPINS-1:0]   cpu_pin_handled,
    input  wire logic               cpu_restore,
    output logic [NPINS-1:0]        irq_req,
    output logic [NPINS-1:0]        lvl_req,
    output logic                    bank_use,
    output logic                    bank_ovf_en,
    output logic [3:0]              bank_ptr
);
    eibc_state_type   st_r;
    eibc_state_type   st_nxt;
    logic [NPINS-1:0] el_now;
    logic [NPINS-1:0] el_prev;
    logic [NPINS-1:0] lo_now;
    logic [NPINS-1:0] edge_hit;
    logic [NPINS-1:0] is_level;

    initial begin
        if (NPINS != 8) $error("NPINS must be 8");
        if (NBANK < 1 || NBANK > 15) $error("NBANK out of range");
    end

    eibc_pin_sync #(.WIDTH(NPINS)) u_el_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .pin_in   (edge_level_request_pin),
        .pin_now  (el_now),
        .pin_prev (el_prev)
    );

    eibc_pin_sync #(.WIDTH(NPINS)) u_lo_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .pin_in   (level_only_request_pin),
        .pin_now  (lo_now),
        .pin_prev ()
    );

    eibc_edge_detect #(.WIDTH(NPINS)) u_edge (
        .now_v    (el_now),
        .prev_v   (el_prev),
        .sense    (st_r.sense),
        .edge_hit (edge_hit),
        .is_level (is_level)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) r[7:0] = d[7:0];
        if (sel[1]) r[15:8] = d[15:8];
        return r;
    endfunction

    logic        req;
    logic        wr;
    logic        rd;
    logic [15:0] wv;
    logic        use_bank;
    always_comb begin
        st_nxt   = st_r;
        req      = wb_cyc_i && wb_stb_i && (st_r.bus == EIBC_BUS_IDLE);
        wr       = req && wb_we_i;
        rd       = req && !wb_we_i;
        wv       = 16'h0000;
        use_bank = 1'b0;
        st_nxt.ack = 1'b0;
        st_nxt.bus = EIBC_BUS_IDLE;
        if (req) begin
            st_nxt.ack = 1'b1;
            st_nxt.bus = EIBC_BUS_ACK;
        end

        // Level-only requests: polarity then enable gate
        for (int i = 0; i < NPINS; i++) begin
            st_nxt.lvl_req[i] = (lo_now[i] == st_r.polarity[i]) && st_r.lvl_en[i]; // R03 R08 R09
        end

        // Request flags
        for (int i = 0; i < NPINS; i++) begin
            if (is_level[i]) begin
                st_nxt.flags[i] = ~el_now[i]; // R04
                st_nxt.armed[i] = 1'b0;
            end else begin
                // Clear first so a simultaneous edge wins
                if (wr && wb_adr_i == `EIBC_OFS_FLAGS && wb_sel_i[0] && !wb_dat_i[i] && st_r.armed[i]) begin
                    st_nxt.flags[i] = 1'b0; // R06
                    st_nxt.armed[i] = 1'b0;
                end
                if (cpu_pin_handled[i]) begin
                    st_nxt.flags[i] = 1'b0; // R07
                    st_nxt.armed[i] = 1'b0;
                end
                if (edge_hit[i]) begin
                    st_nxt.flags[i] = 1'b1; // R05 R21
                end
            end
        end

        // Read data and read side effects
        if (rd) begin
            if (wb_adr_i == `EIBC_OFS_SENSE) begin
                st_nxt.dat = st_r.sense; // R02
            end else if (wb_adr_i == `EIBC_OFS_POLARITY) begin
                st_nxt.dat = {8'h00, st_r.polarity}; // R20
            end else if (wb_adr_i == `EIBC_OFS_FLAGS) begin
                st_nxt.dat = {8'h00, st_r.flags};
                // Builds on this cycle's clears so a flag cleared by the CPU is not armed again
                st_nxt.armed = st_nxt.armed | (st_r.flags & st_nxt.flags & ~is_level); // R06
            end else if (wb_adr_i == `EIBC_OFS_LVL_EN) begin
                st_nxt.dat = {8'h00, st_r.lvl_en};
            end else if (wb_adr_i == `EIBC_OFS_LVL_STAT) begin
                st_nxt.dat = {8'h00, st_r.lvl_req}; // R09
            end else if (wb_adr_i == `EIBC_OFS_BANK_EN) begin
                st_nxt.dat = st_r.bank_en & `EIBC_BANK_EN_MASK; // R10 R20
            end else if (wb_adr_i == `EIBC_OFS_BANK_NUM) begin
                st_nxt.dat = {st_r.mode, st_r.bank_overflow_exception_enable, 9'h000, st_r.bank_ptr}; // R20
            end else begin
                st_nxt.dat = 16'h0000;
            end
        end

        // Register writes
        if (wr) begin
            if (wb_adr_i == `EIBC_OFS_SENSE) begin
                st_nxt.sense = merge16(st_r.sense, wb_dat_i, wb_sel_i); // R01 R02
            end else if (wb_adr_i == `EIBC_OFS_POLARITY) begin
                wv = merge16({8'h00, st_r.polarity}, wb_dat_i, wb_sel_i);
                st_nxt.polarity = wv[7:0]; // R03
            end else if (wb_adr_i == `EIBC_OFS_LVL_EN) begin
                wv = merge16({8'h00, st_r.lvl_en}, wb_dat_i, wb_sel_i);
                st_nxt.lvl_en = wv[7:0]; // R08
            end else if (wb_adr_i == `EIBC_OFS_BANK_EN) begin
                st_nxt.bank_en = merge16(st_r.bank_en, wb_dat_i, wb_sel_i) & `EIBC_BANK_EN_MASK; // R10
            end else if (wb_adr_i == `EIBC_OFS_BANK_NUM && wb_sel_i[1]) begin
                st_nxt.mode = wb_dat_i[`EIBC_MODE_HI:`EIBC_MODE_LO]; // R14
                st_nxt.bank_overflow_exception_enable = wb_dat_i[`EIBC_BANK_OVERFLOW_EXCEPTION_ENABLE_BIT]; // R16
            end
        end

        // Bank decision for an accepted interrupt
        case (st_r.mode)
            `EIBC_MODE_ALL:   use_bank = !cpu_is_nmi && !cpu_is_ubrk; // R13
            `EIBC_MODE_LEVEL: use_bank = !cpu_is_ubrk && st_r.bank_en[cpu_level] && cpu_level != 4'h0; // R15 R11
            default:          use_bank = 1'b0; // R12
        endcase
        use_bank = use_bank && cpu_accept && !cpu_is_ubrk; // R11
        st_nxt.bank_use = use_bank;
        // Overflow when all banks are full and the exception is enabled
        st_nxt.bank_ovf = use_bank && st_r.bank_overflow_exception_enable && (st_r.bank_ptr >= 4'(NBANK)); // R16

        if (use_bank && st_r.bank_ptr < 4'(NBANK)) begin
            st_nxt.bank_ptr = st_r.bank_ptr + 4'h1; // R17
        end else if (cpu_restore && st_r.bank_ptr != 4'h0) begin
            st_nxt.bank_ptr = st_r.bank_ptr - 4'h1; // R18
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            st_r <= '0; // R19
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o    = {16'h0000, st_r.dat};
    assign wb_ack_o    = st_r.ack;
    assign irq_req     = st_r.flags;
    assign lvl_req     = st_r.lvl_req;
    assign bank_use    = st_r.bank_use;
    assign bank_ovf_en = st_r.bank_ovf;
    assign bank_ptr    = st_r.bank_ptr;

    a_edge_sets: assert property (@(posedge clock) disable iff (sys_rst)
        (!is_level[0] && edge_hit[0]) |=> irq_req[0]) else $error("edge did not set flag"); // R05
    a_level_follow: assert property (@(posedge clock) disable iff (sys_rst)
        (is_level[1] && $stable(st_r.sense)) |=> (irq_req[1] == ~$past(el_now[1]))) else $error("level flag wrong"); // R04
    a_blind_clear: assert property (@(posedge clock) disable iff (sys_rst)
        (irq_req[2] && !st_r.armed[2] && !is_level[2] && !cpu_pin_handled[2]) |=> irq_req[2])
        else $error("flag cleared without read"); // R06
    a_cpu_clear: assert property (@(posedge clock) disable iff (sys_rst)
        (!is_level[3] && cpu_pin_handled[3] && !edge_hit[3]) |=> !irq_req[3]) else $error("handled flag kept"); // R07
    a_mode_off: assert property (@(posedge clock) disable iff (sys_rst)
        (st_r.mode == `EIBC_MODE_OFF) |=> !bank_use) else $error("bank used while off"); // R12
    a_ubrk_nobank: assert property (@(posedge clock) disable iff (sys_rst)
        cpu_is_ubrk |=> !bank_use) else $error("bank used for user break"); // R11
    a_ptr_inc: assert property (@(posedge clock) disable iff (sys_rst)
        (use_bank && bank_ptr < 4'(NBANK)) |=> bank_ptr == $past(bank_ptr) + 4'h1) else $error("pointer not bumped"); // R17
    a_ptr_dec: assert property (@(posedge clock) disable iff (sys_rst)
        (cpu_restore && !use_bank && bank_ptr != 4'h0) |=> bank_ptr == $past(bank_ptr) - 4'h1)
        else $error("pointer not dropped"); // R18
    a_lvl_gate: assert property (@(posedge clock) disable iff (sys_rst)
        !st_r.lvl_en[4] [*2] |-> !lvl_req[4]) else $error("disabled pin passed"); // R08
    a_bank_rsvd: assert property (@(posedge clock) disable iff (sys_rst)
        !st_r.bank_en[0]) else $error("bank enable bit 0 set"); // R10
endmodule

// ---- sim/eibc_cpu_model.sv ----
// CPU side model: turns one-cycle bench requests into registered event pulses.
// Assumes the bench raises each request for exactly one clock, after a rising edge.
`timescale 1ns/1ps
module eibc_cpu_model import eibc_pkg::*; (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire eibc_cpu_evt_type req,
    input  wire logic [7:0]       hnd_req,
    output eibc_cpu_evt_type      evt,
    output logic      [7:0]       pin_handled
);
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            evt         <= '0;
            pin_handled <= '0;
        end else begin
            // Qualifiers wander between accepts so stale values are never trusted
            evt         <= req.accept ? req : eibc_cpu_evt_type'{accept: 1'b0, level: ~evt.level,
                                                                 is_nmi: ~evt.is_nmi, is_ubrk: ~evt.is_ubrk,
                                                                 restore: req.restore};
            pin_handled <= hnd_req;
        end
    end
endmodule

// ---- sim/ext_irq_detect_and_bank_ctl_tb.sv ----
// Self-checking bench for the external request and bank control block.
// Assumes eibc_pkg and the CPU model are compiled before it.
`timescale 1ns/1ps
`include "eibc_defs.svh"
module ext_irq_detect_and_bank_ctl_tb import eibc_pkg::*; ;
    logic             clock, sys_rst, cyc, stb, we, ack, bank_use, ovf;
    logic [7:0]       adr, elp, lop, hnd, irq_req, lvl_req;
    logic [31:0]      wdat, dat_o, rdat, seed;
    logic [3:0]       bank_ptr;
    logic [15:0]      s;
    eibc_cpu_evt_type req, evt;
    int               n_fail, num_checks, exp_ptr;
    logic [7:0]       ta [5] = '{8'h00, 8'h04, 8'h0C, 8'h14, 8'h18};
    logic [15:0]      tm [5] = '{16'hFFFF, 16'h00FF, 16'h00FF, 16'hFFFE, 16'hE000};
    logic [1:0]       bmd [7] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h3, 2'h3, 2'h3};
    logic [15:0]      ben [7] = '{16'hFFFE, 16'h0, 16'h0, 16'h0, 16'h0020, 16'h0020, 16'hFFFE};
    logic [3:0]       blv [7] = '{4'h5, 4'h5, 4'hF, 4'hF, 4'h5, 4'h6, 4'hF};
    logic [2:0]       bk [7] = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h1, 3'h0, 3'h2};
    logic [7:0]       hnd_q;

    eibc_top u_dut (
        .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .edge_level_request_pin(elp), .level_only_request_pin(lop), .cpu_accept(evt.accept),
        .cpu_level(evt.level), .cpu_is_nmi(evt.is_nmi), .cpu_is_ubrk(evt.is_ubrk),
        .cpu_pin_handled(hnd_q), .cpu_restore(evt.restore), .irq_req(irq_req), .lvl_req(lvl_req),
        .bank_use(bank_use), .bank_ovf_en(ovf), .bank_ptr(bank_ptr)
    );
    eibc_cpu_model u_cpu (
        .clock(clock), .sys_rst(sys_rst), .req(req), .hnd_req(hnd), .evt(evt), .pin_handled(hnd_q)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // Low-level pins read 1 while low; fall-sensing pins latch unless handled
    function automatic logic [31:0] fall_exp(input logic [15:0] sc, input logic h);
        fall_exp = '0;
        for (int n = 0; n < 8; n++) fall_exp[n] = (sc[2*n+:2] == `EIBC_SENSE_LOW) | (sc[2*n] & !h);
    endfunction
    function automatic logic [31:0] fexp(input logic [1:0] c, input logic rise, input logic cl);
        logic edg;
        edg = (c != `EIBC_SENSE_LOW) && !cl && (rise ? c[1] : c[0]);
        return {24'h0, {8{edg | (c == `EIBC_SENSE_LOW && !rise)}}};
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask
    // Classic cycle held until ack is sampled high; bounded wait
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (ack !== 1'b1 && i < 20);
        if (ack !== 1'b1) begin
            n_fail++;
            test_done();
        end
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic clr();
        wb(1'b0, `EIBC_OFS_FLAGS, 32'h0);
        wb(1'b1, `EIBC_OFS_FLAGS, 32'h0);
    endtask
    task automatic cpu(input logic acc, input logic [3:0] l, input logic n, input logic u, input logic r);
        @(posedge clock);
        req <= '{accept: acc, level: l, is_nmi: n, is_ubrk: u, restore: r};
        @(posedge clock);
        req <= '0;
        @(posedge clock);
        #1;
    endtask

    initial begin
        {cyc, stb, we, adr, wdat, hnd, req} = '0;
        {elp, lop} = 16'hFFFF;
        sys_rst = 1'b1;
        seed = 32'hD52D;
        {n_fail, num_checks, exp_ptr} = '0;
        tick(12);
        sys_rst <= 1'b0;
        for (int a = 0; a < 8; a++) rd(8'(4 * a), 32'h0);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            s = seed[15:0] | 16'h4000;
            wb(1'b1, ta[i], {16'h0, s});
            rd(ta[i], {16'h0, s & tm[i]});
        end
        wb(1'b1, `EIBC_OFS_BANK_NUM, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, `EIBC_OFS_SENSE, {16'h0, {8{2'(c)}}});
            clr();
            for (int r = 0; r < 2; r++) begin
                @(posedge clock);
                elp <= r[0] ? 8'hFF : 8'h00;
                tick(4);
                chk({24'h0, irq_req}, fexp(2'(c), r[0], 1'b0));
                wb(1'b1, `EIBC_OFS_FLAGS, 32'h0);
                rd(`EIBC_OFS_FLAGS, fexp(2'(c), r[0], 1'b0));
                wb(1'b1, `EIBC_OFS_FLAGS, 32'h0);
                rd(`EIBC_OFS_FLAGS, fexp(2'(c), r[0], 1'b1));
            end
        end
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            s = seed[15:0];
            wb(1'b1, `EIBC_OFS_SENSE, {16'h0, s});
            clr();
            @(posedge clock);
            elp <= 8'h00;
            tick(4);
            rd(`EIBC_OFS_FLAGS, fall_exp(s, 1'b0));
            @(posedge clock);
            hnd <= 8'hFF;
            @(posedge clock);
            hnd <= 8'h00;
            tick(3);
            chk({24'h0, irq_req}, fall_exp(s, 1'b1));
            @(posedge clock);
            elp <= 8'hFF;
            tick(4);
        end
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            wb(1'b1, `EIBC_OFS_POLARITY, {24'h0, seed[7:0]});
            wb(1'b1, `EIBC_OFS_LVL_EN, {24'h0, seed[15:8]});
            @(posedge clock);
            lop <= seed[23:16];
            tick(5);
            chk({24'h0, lvl_req}, {24'h0, seed[15:8] & ~(seed[23:16] ^ seed[7:0])});
            wb(1'b1, `EIBC_OFS_LVL_EN, 32'hFF);
            rd(`EIBC_OFS_LVL_STAT, {24'h0, ~(seed[23:16] ^ seed[7:0])});
        end
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, `EIBC_OFS_BANK_EN, {16'h0, ben[i]});
            wb(1'b1, `EIBC_OFS_BANK_NUM, {16'h0, bmd[i], 14'h0});
            cpu(1'b1, blv[i], bk[i][2], bk[i][1], 1'b0);
            exp_ptr += int'(bk[i][0]);
            chk({31'h0, bank_use}, {31'h0, bk[i][0]});
            chk({28'h0, bank_ptr}, exp_ptr);
        end
        rd(`EIBC_OFS_BANK_NUM, {16'h0, 2'h3, 10'h0, 4'(exp_ptr)});
        cpu(1'b0, 4'h0, 1'b0, 1'b0, 1'b1);
        exp_ptr--;
        chk({28'h0, bank_ptr}, exp_ptr);
        wb(1'b1, `EIBC_OFS_BANK_NUM, 32'h6000);
        for (int i = 0; i < 16; i++) begin
            if (i == 15) wb(1'b1, `EIBC_OFS_BANK_NUM, 32'h4000);
            cpu(1'b1, 4'h3, 1'b0, 1'b0, 1'b0);
            chk({31'h0, ovf}, {31'h0, exp_ptr == 15 && i < 15});
            if (exp_ptr < 15) exp_ptr++;
            chk({28'h0, bank_ptr}, exp_ptr);
        end
        test_done();
    end
endmodule
